// ==== src/parallel_io_ports.v ====
`timescale 1ns/10ps
`include "parallel_io_regs.vh"
// Operation
// - twelve lines, eight on port A and four on port B, each in or out
// - direction bit one makes the line an output
// - direction bit zero makes the line an input
// - reset clears every direction register, all lines inputs
// - direction registers are writable and readable
// - data read of an output line returns the latch, not the pin
// - data read of an input line returns the sampled pin
// - data write to an input line only updates the latch
// - data write to an output line updates latch and drives pin
// - port A data at address zero, direction at address two
// - open-drain bit at address four makes an output line open drain
// - open-drain setting on an input line has no effect
// - open-drain output floats for latch one, drives low for zero
// - reset clears port A direction and open-drain bits
// - reset leaves port A data latch unchanged
// - each port B line can request an interrupt while low
// - port B data at address one, direction at address three
// - port B low sets sticky flag, cleared by reset or written zero
// - request when flag and enable set and global mask clear
// - unused port B register bits read as zero
module parallel_io_ports
#(
   parameter PA_W = `PA_W,
   parameter PB_W = `PB_W
)
(
   // clock and reset
   input  wire              ref_clk,
   input  wire              srst,
   // register port
   input  wire [`ADDR_W-1:0] addr,
   input  wire [7:0]        wdata,
   input  wire              wr,
   input  wire              rd,
   output wire [7:0]        rdata,
   // processor interrupt mask
   input  wire              irq_mask,
   output wire              port_b_irq,
   // port A pins
   input  wire [PA_W-1:0]   port_a_lines_in,
   output wire [PA_W-1:0]   port_a_lines_out,
   output wire [PA_W-1:0]   port_a_lines_oe_n,
   // port B pins
   input  wire [PB_W-1:0]   port_b_lines_in,
   output wire [PB_W-1:0]   port_b_lines_out,
   output wire [PB_W-1:0]   port_b_lines_oe_n
);
   reg  [PA_W-1:0] pa_latch_reg;
   reg  [PA_W-1:0] pa_dir_reg;
   reg  [PA_W-1:0] pa_od_reg;
   reg  [PB_W-1:0] pb_latch_reg;
   reg  [PB_W-1:0] pb_dir_reg;
   reg  [PB_W-1:0] low_event_enables_reg;
   reg  [PB_W-1:0] low_event_flags_reg;
   reg  [PB_W-1:0] flags_next;
   reg  [7:0]      rdata_reg;
   reg  [7:0]      rdata_next;
   wire [PA_W-1:0] pa_level;
   wire [PB_W-1:0] pb_level;
   wire [PB_W-1:0] pb_eff;
   wire [PA_W-1:0] pa_read;
   wire [PB_W-1:0] pb_read;

   pin_sync #(.W(PA_W)) u_sync_a
   (
      .ref_clk (ref_clk),
      .pin_in  (port_a_lines_in),
      .level   (pa_level)
   );

   pin_sync #(.W(PB_W)) u_sync_b
   (
      .ref_clk (ref_clk),
      .pin_in  (port_b_lines_in),
      .level   (pb_level)
   );

   // port A drive, open drain only matters for output lines
   pin_driver #(.W(PA_W)) u_drv_a
   (
      .dir        (pa_dir_reg),
      .open_drain (pa_od_reg & pa_dir_reg),
      .latch      (pa_latch_reg),
      .pin_out    (port_a_lines_out),
      .pin_oe_n   (port_a_lines_oe_n)
   );

   assign port_b_lines_out  = pb_latch_reg;
   assign port_b_lines_oe_n = ~pb_dir_reg;

   // line value seen by the port: latch for outputs, pin for inputs
   assign pa_read = (pa_dir_reg & pa_latch_reg) | (~pa_dir_reg & pa_level);
   assign pb_read = (pb_dir_reg & pb_latch_reg) | (~pb_dir_reg & pb_level);
   assign pb_eff  = pb_read;

   // data latches have no reset
   always @(posedge ref_clk)
   begin
      if (wr && addr == `ADDR_PA_DATA)
         pa_latch_reg <= wdata[PA_W-1:0];
      if (wr && addr == `ADDR_PB_DATA)
         pb_latch_reg <= wdata[PB_W-1:0];
   end

   // flag update: a low line sets, written zero clears, set wins
   always @*
   begin
      flags_next = low_event_flags_reg;
      if (wr && addr == `ADDR_PB_FLAGS)
         flags_next = low_event_flags_reg & wdata[PB_W-1:0];
      flags_next = flags_next | ~pb_eff;
   end

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         pa_dir_reg            <= `RST_PA_DIR;
         pa_od_reg             <= `RST_PA_OD;
         pb_dir_reg            <= `RST_PB_DIR;
         low_event_enables_reg <= `RST_PB_ENABLE;
         low_event_flags_reg   <= `RST_PB_FLAGS;
      end
      else
      begin
         if (wr && addr == `ADDR_PA_DIR)
            pa_dir_reg <= wdata[PA_W-1:0];
         if (wr && addr == `ADDR_PA_OD)
            pa_od_reg <= wdata[PA_W-1:0];
         if (wr && addr == `ADDR_PB_DIR)
            pb_dir_reg <= wdata[PB_W-1:0];
         if (wr && addr == `ADDR_PB_ENABLE)
            low_event_enables_reg <= wdata[PB_W-1:0];
         low_event_flags_reg <= flags_next;
      end
   end

   assign port_b_irq = |(low_event_flags_reg & low_event_enables_reg) & ~irq_mask;

   // read mux, unused upper bits zero
   always @*
   begin
      rdata_next = 8'h00;
      case (addr)
         `ADDR_PA_DATA:   rdata_next[PA_W-1:0] = pa_read;
         `ADDR_PB_DATA:   rdata_next[PB_W-1:0] = pb_read;
         `ADDR_PA_DIR:    rdata_next[PA_W-1:0] = pa_dir_reg;
         `ADDR_PB_DIR:    rdata_next[PB_W-1:0] = pb_dir_reg;
         `ADDR_PA_OD:     rdata_next[PA_W-1:0] = pa_od_reg;
         `ADDR_PB_ENABLE: rdata_next[PB_W-1:0] = low_event_enables_reg;
         `ADDR_PB_FLAGS:  rdata_next[PB_W-1:0] = low_event_flags_reg;
         `ADDR_PB_PEND:   rdata_next[PB_W-1:0] = low_event_flags_reg & low_event_enables_reg;
         default:         rdata_next = 8'h00;
      endcase
   end

   always @(posedge ref_clk)
   begin
      if (srst)
         rdata_reg <= 8'h00;
      else if (rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= 8'h00;
   end

   assign rdata = rdata_reg;
endmodule

// ==== src/parallel_io_regs.vh ====
`ifndef PARALLEL_IO_REGS_VH
`define PARALLEL_IO_REGS_VH
// register offsets
`define ADDR_PA_DATA      3'h0
`define ADDR_PB_DATA      3'h1
`define ADDR_PA_DIR       3'h2
`define ADDR_PB_DIR       3'h3
`define ADDR_PA_OD        3'h4
`define ADDR_PB_ENABLE    3'h5
`define ADDR_PB_FLAGS     3'h6
`define ADDR_PB_PEND      3'h7
// widths
`define ADDR_W            3
`define PA_W              8
`define PB_W              4
// reset values
`define RST_PA_DIR        8'h00
`define RST_PA_OD         8'h00
`define RST_PB_DIR        4'h0
`define RST_PB_ENABLE     4'h0
`define RST_PB_FLAGS      4'h0
`endif

// ==== src/pin_sync.v ====
`timescale 1ns/10ps
// three-stage sampler; a change is accepted once stages two and three agree
module pin_sync
#(
   parameter W = 8
)
(
   // clock
   input  wire         ref_clk,
   // pins and sampled level
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] level
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   reg [W-1:0] lvl_reg;
   genvar i;
   always @(posedge ref_clk)
   begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge ref_clk)
         begin
            if (s2_reg[i] == s3_reg[i])
               lvl_reg[i] <= s3_reg[i];
         end
      end
   endgenerate
   assign level = lvl_reg;
endmodule

// ==== src/pin_driver.v ====
`timescale 1ns/10ps
// per-line output drive; oe_n low means driving
module pin_driver
#(
   parameter W = 8
)
(
   // configuration
   input  wire [W-1:0] dir,
   input  wire [W-1:0] open_drain,
   input  wire [W-1:0] latch,
   // pin
   output wire [W-1:0] pin_out,
   output wire [W-1:0] pin_oe_n
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_line
         // open drain pulls low only, floats for a one
         assign pin_out[i]  = open_drain[i] ? 1'b0 : latch[i];
         assign pin_oe_n[i] = ~(dir[i] & (~open_drain[i] | ~latch[i]));
      end
   endgenerate
endmodule

// ==== bench/pin_load.sv ====
`timescale 1ns/10ps
// strong external load wins; a released line floats up to the pull-up
module pin_load
#(
   parameter W = 8
)
(
   input  wire [W-1:0] out,
   input  wire [W-1:0] oe_n,
   input  wire [W-1:0] pull_en,
   input  wire [W-1:0] pull_val,
   output wire [W-1:0] lvl
);
   assign lvl = (pull_en & pull_val) | (~pull_en & ((~oe_n & out) | oe_n));
endmodule

// ==== bench/parallel_io_ports_asserts.sv ====
`timescale 1ns/10ps
module parallel_io_ports_chk
(
   input wire       ref_clk,
   input wire       srst,
   input wire [2:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   input wire       irq_mask,
   input wire       port_b_irq,
   input wire [7:0] port_a_lines_out,
   input wire [7:0] port_a_lines_oe_n,
   input wire [3:0] port_b_lines_out,
   input wire [3:0] port_b_lines_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_reset_inputs: assert property (disable iff (1'b0) srst |=>
      &port_a_lines_oe_n && &port_b_lines_oe_n) else $error("lines driven after reset");
   a_dir_gates_a: assert property (wr && addr == 3'h2 |=>
      (~port_a_lines_oe_n & ~$past(wdata)) == 8'h00) else $error("input line driven");
   a_dir_drives_b: assert property (wr && addr == 3'h3 |=>
      port_b_lines_oe_n == ~$past(wdata[3:0])) else $error("port b drive wrong");
   a_out_follows_b: assert property (wr && addr == 3'h1 |=>
      ((port_b_lines_out ^ $past(wdata[3:0])) & ~port_b_lines_oe_n) == 4'h0)
      else $error("port b pin value wrong");
   a_out_follows_a: assert property (wr && addr == 3'h0 |=>
      ((port_a_lines_out ^ $past(wdata)) & ~port_a_lines_oe_n) == 8'h00)
      else $error("port a pin value wrong");
   a_dir_readback: assert property (wr && addr == 3'h2 ##2 rd && addr == 3'h2 |=>
      rdata == $past(wdata, 3)) else $error("direction readback wrong");
   a_pb_high_zero: assert property (rd && addr[0] |=> rdata[7:4] == 4'h0)
      else $error("unused bits not zero");
   a_mask_blocks: assert property (irq_mask |-> !port_b_irq)
      else $error("request while masked");
   c_irq: cover property (port_b_irq);
   c_od_float: cover property (!port_a_lines_oe_n[2] ##1 port_a_lines_oe_n[2]);
   c_readback: cover property (wr && addr == 3'h2 ##2 rd && addr == 3'h2);
endmodule
bind parallel_io_ports parallel_io_ports_chk i_chk (.*);

// ==== bench/parallel_io_ports_tb_top.sv ====
`timescale 1ns/10ps
module parallel_io_ports_tb_top;
   reg         ref_clk = 1'b0;
   reg         srst = 1'b1;
   reg  [2:0]  addr = 3'h0;
   reg  [7:0]  wdata = 8'h00;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg         irq_mask = 1'b1;
   reg  [7:0]  a_en = 8'h00;
   reg  [7:0]  a_val = 8'h00;
   reg  [3:0]  b_en = 4'h0;
   wire [7:0]  rdata, a_out, a_oe_n, a_lvl;
   wire [3:0]  b_out, b_oe_n, b_lvl;
   wire        irq;
   integer     failures = 0;
   integer     comparisons = 0;
   integer     i;
   reg  [18:0] rows [0:5];
   always #5 ref_clk = ~ref_clk;
   parallel_io_ports i_dut (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq_mask(irq_mask), .port_b_irq(irq),
      .port_a_lines_in(a_lvl), .port_a_lines_out(a_out), .port_a_lines_oe_n(a_oe_n),
      .port_b_lines_in(b_lvl), .port_b_lines_out(b_out), .port_b_lines_oe_n(b_oe_n));
   pin_load #(.W(8)) i_la (.out(a_out), .oe_n(a_oe_n), .pull_en(a_en), .pull_val(a_val),
      .lvl(a_lvl));
   pin_load #(.W(4)) i_lb (.out(b_out), .oe_n(b_oe_n), .pull_en(b_en), .pull_val(4'h0),
      .lvl(b_lvl));
   task cmp8(input [7:0] got, input [7:0] exp);
   begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   end
   endtask
   task wr_reg(input [2:0] a, input [7:0] d);
   begin
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   end
   endtask
   task rd_chk(input [2:0] a, input [7:0] e);
   begin
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 cmp8(rdata, e);
   end
   endtask
   task final_report;
   begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      // address, write data, expected read
      rows[0] = {3'h2, 8'hA5, 8'hA5};
      rows[1] = {3'h3, 8'hFF, 8'h0F};
      rows[2] = {3'h4, 8'h3C, 8'h3C};
      rows[3] = {3'h5, 8'hFF, 8'h0F};
      rows[4] = {3'h2, 8'hFF, 8'hFF};
      rows[5] = {3'h0, 8'h5A, 8'h5A};
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      cmp8({a_oe_n[7:4], b_oe_n}, 8'hFF);
      cmp8(a_oe_n, 8'hFF);
      rd_chk(3'h2, 8'h00);
      rd_chk(3'h4, 8'h00);
      rd_chk(3'h3, 8'h00);
      for (i = 0; i < 6; i = i + 1)
      begin
         wr_reg(rows[i][18:16], rows[i][15:8]);
         rd_chk(rows[i][18:16], rows[i][7:0]);
      end
      cmp8(a_oe_n, 8'h18);
      cmp8(a_out & 8'hC3, 8'h42);
      a_en <= 8'hFF;
      rd_chk(3'h0, 8'h5A);
      a_val <= 8'hC3;
      wr_reg(3'h2, 8'h00);
      wr_reg(3'h0, 8'h0F);
      cmp8(a_oe_n, 8'hFF);
      repeat (6) @(posedge ref_clk);
      rd_chk(3'h0, 8'hC3);
      a_en <= 8'h00;
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd_chk(3'h2, 8'h00);
      wr_reg(3'h2, 8'hFF);
      rd_chk(3'h0, 8'h0F);
      wr_reg(3'h6, 8'h00);
      wr_reg(3'h5, 8'h01);
      irq_mask <= 1'b0;
      b_en <= 4'h1;
      repeat (6) @(posedge ref_clk);
      b_en <= 4'h0;
      repeat (6) @(posedge ref_clk);
      rd_chk(3'h6, 8'h01);
      cmp8({7'h00, irq}, 8'h01);
      irq_mask <= 1'b1;
      @(posedge ref_clk);
      #1 cmp8({7'h00, irq}, 8'h00);
      wr_reg(3'h6, 8'h00);
      rd_chk(3'h6, 8'h00);
      wr_reg(3'h1, 8'h0E);
      wr_reg(3'h3, 8'h01);
      repeat (3) @(posedge ref_clk);
      #1 cmp8({3'h0, b_out[0], b_oe_n}, 8'h0E);
      wr_reg(3'h7, 8'hFF);
      rd_chk(3'h7, 8'h01);
      final_report;
   end
endmodule
